// >>> verilog/cp0_debug_defs.svh
// offsets, field positions, fixed read values and widths for the debug/cache regs
`ifndef CP0_DEBUG_DEFS_SVH
`define CP0_DEBUG_DEFS_SVH

// register indices and byte addresses (byte address is four times index)
`define IDX_DEBUG_STATUS  8'h17
`define IDX_RESUME_CNT    8'h18
`define IDX_CACHE_TEST    8'h1a
`define IDX_TAG_STAGING   8'h1c
`define IDX_DATA_STAGING  8'h1d
`define ADDR_DEBUG_STATUS 8'h5c
`define ADDR_RESUME_CNT   8'h60
`define ADDR_CACHE_TEST   8'h68
`define ADDR_TAG_STAGING  8'h70
`define ADDR_DATA_STAGING 8'h74

// debug status low fields
`define DBG_CAUSE_HI      14
`define DBG_CAUSE_LO      10
`define DBG_STEP_ABS_BIT  9
`define DBG_STEP_EN_BIT   8
`define DBG_INT_BIT       5
`define DBG_INSTR_BIT     4
`define DBG_STORE_BIT     3
`define DBG_LOAD_BIT      2
`define DBG_SWBP_BIT      1
`define DBG_STEP_BIT      0
`define SINGLE_STEP_ABSENT 1'b0

// cache test control fields
`define CTL_WAYTEST_BIT   29
`define CTL_SCRATCH_BIT   28

// tag staging fields
`define TAG_ADDR_HI       31
`define TAG_ADDR_LO       10
`define TAG_VALID_HI      7
`define TAG_VALID_LO      4
`define TAG_LOCK_BIT      2
`define TAG_HIST_BIT      1
`define WAYSEL_W          6

`define CACHE_IDX_W       12
`define ZERO32            32'h0000_0000

`endif

// >>> verilog/cp0_debug_pkg.sv
// types shared by the debug cause and cache test register block
package cp0_debug_pkg;

    // indexed cache operation kinds
    typedef enum logic [1:0] {
        CACHE_LOAD_TAG   = 2'h0,
        CACHE_STORE_TAG  = 2'h1,
        CACHE_STORE_DATA = 2'h3
    } cache_op_t;

    // whole register state of the block
    typedef struct packed {
        logic [4:0]  debugCause;
        logic        singleStep;
        logic [5:0]  flags;
        logic [31:0] resumePc;
        logic        delaySlot;
        logic        wayTest;
        logic        scratch;
        logic [21:0] tagAddr;
        logic [3:0]  tagValid;
        logic        tagLock;
        logic        tagHist;
        logic [31:0] dataStage;
        logic [31:0] rdata;
        logic        resumeJump;
        logic        tagReq;
        logic        waySelReq;
        logic        dataReq;
        logic        scratchReq;
        logic        reqWrite;
        logic [31:0] reqWdata;
        logic [11:0] reqIndex;
    } regs_t;

endpackage

// >>> verilog/debug_cause_and_cache_test_regs.sv
// debug cause, resume counter, cache test control and tag staging registers
`timescale 1ns/10ps
`include "cp0_debug_defs.svh"

//Behaviour
//- latest debug-mode exception cause held read-only in five bits
//- single-step absent bit reads zero, feature present
//- single-step enable bit, writable, resets to zero
//- reserved debug status bits 7:6 always read zero
//- debug interrupt flag set on entry, cleared by debug-mode exception
//- instruction break flag set on entry, cleared by debug-mode exception
//- store data break flag set on entry, cleared by debug-mode exception
//- load data break flag set on entry, cleared by debug-mode exception
//- software breakpoint flag set on entry, cleared by debug-mode exception
//- single-step flag set on entry, cleared by debug-mode exception
//- precise exception loads causing address, or branch address plus flag
//- debug interrupt loads the address where execution resumes
//- debug return jumps to resume counter; counter readable and writable
//- way-select test sends tag load/store to way-select RAM only
//- way-select test uses low six address bits of tag staging
//- way-select test enables indexed data store from data staging
//- scratchpad routing sends indexed tag and data ops to scratchpad
//- unused cache test bits read zero; both control bits reset zero
//- tag staging upper 22 bits hold line physical address
//- tag staging holds four per-word valid bits
//- tag staging holds lock bit keeping line from replacement
//- tag staging history bit inverts on each new line fill unless a non-way-select load tag return lands that cycle
//- indexed data store writes data staging value into data array only in way-select test without scratchpad routing
module debug_cause_and_cache_test_regs (
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    // register port
    input  wire logic [7:0]                 addr,
    input  wire logic [31:0]                wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [31:0]                rdata,
    // debug exception events from the pipeline
    input  wire logic                       debugExcTaken,
    input  wire logic [5:0]                 debugKind,
    input  wire logic                       excInDebug,
    input  wire logic [4:0]                 excCauseCode,
    input  wire logic [31:0]                excPc,
    input  wire logic                       excInDelaySlot,
    input  wire logic [31:0]                excBranchPc,
    input  wire logic                       debugReturn,
    // debug results to the pipeline
    output logic                            singleStepEnable,
    output logic                            delaySlotFlag,
    output logic                            resumeJump,
    output logic      [31:0]                resumeTarget,
    // indexed cache operations
    input  wire logic                       cacheOpValid,
    input  wire cp0_debug_pkg::cache_op_t   cacheOpKind,
    input  wire logic [`CACHE_IDX_W-1:0]    cacheIndex,
    input  wire logic                       loadRetValid,
    input  wire logic [31:0]                loadRetData,
    input  wire logic                       lineFill,
    // requests to cache, way-select, data and scratchpad arrays
    output logic                            tagReq,
    output logic                            waySelReq,
    output logic                            dataReq,
    output logic                            scratchReq,
    output logic                            reqWrite,
    output logic      [31:0]                reqWdata,
    output logic      [`CACHE_IDX_W-1:0]    reqIndex
);
    import cp0_debug_pkg::*;

    regs_t r;
    regs_t next_r;

    // packed image of the tag staging register
    function automatic logic [31:0] tagImage(input regs_t s);
        tagImage = {s.tagAddr, 2'h0, s.tagValid, 1'b0, s.tagLock,
                    s.tagHist, 1'b0};
    endfunction

    // read multiplexer; unmapped addresses return zero
    function automatic logic [31:0] readMux(input regs_t s,
                                            input logic [7:0] a);
        readMux = `ZERO32;
        unique case (a)
            `ADDR_DEBUG_STATUS: begin
                readMux[`DBG_CAUSE_HI:`DBG_CAUSE_LO] = s.debugCause;
                readMux[`DBG_STEP_ABS_BIT] = `SINGLE_STEP_ABSENT;
                readMux[`DBG_STEP_EN_BIT]  = s.singleStep;
                readMux[5:0]            = s.flags;
            end
            `ADDR_RESUME_CNT:   readMux = s.resumePc;
            `ADDR_CACHE_TEST: begin
                readMux[`CTL_WAYTEST_BIT] = s.wayTest;
                readMux[`CTL_SCRATCH_BIT] = s.scratch;
            end
            `ADDR_TAG_STAGING:  readMux = tagImage(s);
            `ADDR_DATA_STAGING: readMux = s.dataStage;
            default:            readMux = `ZERO32;
        endcase
    endfunction

    // next state: software first, hardware events after so they win
    always_comb begin
        next_r            = r;
        next_r.rdata      = `ZERO32;
        next_r.resumeJump = 1'b0;
        next_r.tagReq     = 1'b0;
        next_r.waySelReq  = 1'b0;
        next_r.dataReq    = 1'b0;
        next_r.scratchReq = 1'b0;
        next_r.reqWrite   = 1'b0;

        if (rd) begin
            next_r.rdata = readMux(r, addr);
        end

        // software writes land next cycle for the following instruction
        if (wr) begin
            unique case (addr)
                `ADDR_DEBUG_STATUS: begin
                    next_r.singleStep = wdata[`DBG_STEP_EN_BIT];
                    next_r.flags[`DBG_INT_BIT] = wdata[`DBG_INT_BIT];
                end
                `ADDR_RESUME_CNT: next_r.resumePc = wdata;
                `ADDR_CACHE_TEST: begin
                    next_r.wayTest = wdata[`CTL_WAYTEST_BIT];
                    next_r.scratch = wdata[`CTL_SCRATCH_BIT];
                end
                `ADDR_TAG_STAGING: begin
                    next_r.tagAddr  = wdata[`TAG_ADDR_HI:`TAG_ADDR_LO];
                    next_r.tagValid = wdata[`TAG_VALID_HI:`TAG_VALID_LO];
                    next_r.tagLock  = wdata[`TAG_LOCK_BIT];
                    next_r.tagHist  = wdata[`TAG_HIST_BIT];
                end
                `ADDR_DATA_STAGING: next_r.dataStage = wdata;
                default: ;
            endcase
        end

        // entry into debug mode: exactly the cause bit is set
        if (debugExcTaken) begin
            for (int i = 0; i < 6; i++) begin
                next_r.flags[i] = debugKind[i];
            end
            if (debugKind[`DBG_INT_BIT]) begin
                next_r.resumePc  = excPc;
                next_r.delaySlot = 1'b0;
            end else begin
                next_r.resumePc  = excInDelaySlot ? excBranchPc : excPc;
                next_r.delaySlot = excInDelaySlot;
            end
        end else if (excInDebug) begin
            // debug-mode exception wipes every cause flag
            next_r.flags      = 6'h00;
            next_r.debugCause = excCauseCode;
            next_r.resumePc   = excInDelaySlot ? excBranchPc : excPc;
            next_r.delaySlot  = excInDelaySlot;
        end

        if (debugReturn) begin
            next_r.resumeJump = 1'b1;
        end

        // history bit follows fills of the staged entry
        if (lineFill) begin
            next_r.tagHist = ~r.tagHist;
        end

        // load tag return: way-select data lands in low address bits only
        if (loadRetValid) begin
            if (r.wayTest && !r.scratch) begin
                next_r.tagAddr[`WAYSEL_W-1:0] =
                    loadRetData[`WAYSEL_W-1:0];
            end else begin
                next_r.tagAddr  = loadRetData[`TAG_ADDR_HI:`TAG_ADDR_LO];
                next_r.tagValid = loadRetData[`TAG_VALID_HI:`TAG_VALID_LO];
                next_r.tagLock  = loadRetData[`TAG_LOCK_BIT];
                next_r.tagHist  = loadRetData[`TAG_HIST_BIT];
            end
        end

        // routing of indexed cache operations
        if (cacheOpValid) begin
            next_r.reqIndex = cacheIndex;
            next_r.reqWrite = (cacheOpKind != CACHE_LOAD_TAG);
            next_r.reqWdata = tagImage(r);
            if (cacheOpKind == CACHE_STORE_DATA) begin
                next_r.reqWdata = r.dataStage;
            end else if (r.wayTest && !r.scratch) begin
                next_r.reqWdata = {26'h000_0000,
                                   r.tagAddr[`WAYSEL_W-1:0]};
            end
            if (r.scratch) begin
                next_r.scratchReq = 1'b1;
            end else if (r.wayTest) begin
                next_r.waySelReq = (cacheOpKind != CACHE_STORE_DATA);
                next_r.dataReq   = (cacheOpKind == CACHE_STORE_DATA);
            end else begin
                // data store is ignored outside test mode
                next_r.tagReq   = (cacheOpKind != CACHE_STORE_DATA);
                next_r.reqWrite = (cacheOpKind == CACHE_STORE_TAG);
            end
        end
    end

    // state register; undefined fields still clear for a known start
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from flops
    assign rdata            = r.rdata;
    assign singleStepEnable = r.singleStep;
    assign delaySlotFlag    = r.delaySlot;
    assign resumeJump       = r.resumeJump;
    assign resumeTarget     = r.resumePc;
    assign tagReq           = r.tagReq;
    assign waySelReq        = r.waySelReq;
    assign dataReq          = r.dataReq;
    assign scratchReq       = r.scratchReq;
    assign reqWrite         = r.reqWrite;
    assign reqWdata         = r.reqWdata;
    assign reqIndex         = r.reqIndex;

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence preciseEntry;
        debugExcTaken && !debugKind[`DBG_INT_BIT] && excInDelaySlot;
    endsequence

    sequence modeExc;
        excInDebug && !debugExcTaken;
    endsequence

    a_cause_loaded: assert property (
        modeExc |=> r.debugCause == $past(excCauseCode))
        else $error("debug-mode cause not captured");

    a_step_absent: assert property (
        rd && addr == `ADDR_DEBUG_STATUS |=> !rdata[`DBG_STEP_ABS_BIT])
        else $error("single-step absent bit not zero");

    a_step_write: assert property (
        wr && addr == `ADDR_DEBUG_STATUS ##1 rd && addr == `ADDR_DEBUG_STATUS
        |=> rdata[`DBG_STEP_EN_BIT] == $past(wdata[`DBG_STEP_EN_BIT], 2))
        else $error("single-step enable did not read back");

    a_dbg_reserved: assert property (
        ##1 $past(rd && addr == `ADDR_DEBUG_STATUS) |-> rdata[7:6] == 2'h0)
        else $error("reserved debug bits not zero");

    a_int_flag: assert property (
        debugExcTaken && debugKind[`DBG_INT_BIT] |=> r.flags[`DBG_INT_BIT])
        else $error("debug interrupt flag not set");

    a_flags_clear: assert property (
        modeExc |=> r.flags == 6'h00)
        else $error("cause flags not cleared");

    a_store_flag: assert property (
        debugExcTaken |=> r.flags[`DBG_STORE_BIT] ==
                          $past(debugKind[`DBG_STORE_BIT]))
        else $error("store break flag wrong");

    a_delay_slot: assert property (
        preciseEntry |=> delaySlotFlag && resumeTarget == $past(excBranchPc))
        else $error("delay slot capture wrong");

    a_resume_jump: assert property (
        debugReturn |=> resumeJump ##1 !resumeJump || $past(debugReturn))
        else $error("debug return jump missing");

    a_waysel_only: assert property (
        cacheOpValid && r.wayTest && !r.scratch &&
        cacheOpKind != CACHE_STORE_DATA |=> waySelReq && !tagReq)
        else $error("way-select test touched tag RAM");

    a_scratch_route: assert property (
        cacheOpValid && r.scratch |=> scratchReq && !tagReq && !dataReq)
        else $error("scratchpad routing wrong");

    a_ctl_reserved: assert property (
        rd && addr == `ADDR_CACHE_TEST |=> rdata[31:30] == 2'h0 &&
                                          rdata[27:0] == 28'h000_0000)
        else $error("cache test reserved bits not zero");

    // way-select test op on the tag path, load or store
    sequence wayTagOp;
        cacheOpValid && r.wayTest && !r.scratch &&
        cacheOpKind != CACHE_STORE_DATA;
    endsequence

    sequence tagRead;
        rd && addr == `ADDR_TAG_STAGING;
    endsequence

    a_load_flag: assert property (
        debugExcTaken |=> r.flags[`DBG_LOAD_BIT] ==
                          $past(debugKind[`DBG_LOAD_BIT]))
        else $error("load break flag wrong");

    a_swbp_flag: assert property (
        debugExcTaken |=> r.flags[`DBG_SWBP_BIT] ==
                          $past(debugKind[`DBG_SWBP_BIT]))
        else $error("software breakpoint flag wrong");

    a_int_resume: assert property (
        debugExcTaken && debugKind[`DBG_INT_BIT]
        |=> resumeTarget == $past(excPc) && !delaySlotFlag)
        else $error("interrupt resume address wrong");

    a_precise_pc: assert property (
        debugExcTaken && !debugKind[`DBG_INT_BIT] && !excInDelaySlot
        |=> resumeTarget == $past(excPc) && !delaySlotFlag)
        else $error("precise resume address wrong");

    a_waysel_data: assert property (
        wayTagOp |=> reqWdata == {26'h000_0000,
                                  $past(r.tagAddr[`WAYSEL_W-1:0])})
        else $error("way-select write data wrong");

    a_data_store: assert property (
        cacheOpValid && cacheOpKind == CACHE_STORE_DATA &&
        (r.wayTest || r.scratch)
        |=> reqWrite && reqWdata == $past(r.dataStage))
        else $error("data store value wrong");

    a_data_enable: assert property (
        cacheOpValid && cacheOpKind == CACHE_STORE_DATA && r.wayTest &&
        !r.scratch |=> dataReq && !waySelReq && !tagReq)
        else $error("data store not enabled by way test");

    a_hist_toggle: assert property (
        lineFill && !loadRetValid |=> r.tagHist != $past(r.tagHist))
        else $error("history bit did not invert");

    a_tag_addr: assert property (
        tagRead |=> rdata[`TAG_ADDR_HI:`TAG_ADDR_LO] == $past(r.tagAddr))
        else $error("tag address field wrong");

    a_tag_valid: assert property (
        tagRead |=> rdata[`TAG_VALID_HI:`TAG_VALID_LO] == $past(r.tagValid))
        else $error("tag valid field wrong");

    a_tag_lock: assert property (
        tagRead |=> rdata[`TAG_LOCK_BIT] == $past(r.tagLock))
        else $error("tag lock bit wrong");

    a_write_visible: assert property (
        wr && addr == `ADDR_RESUME_CNT && !debugExcTaken && !excInDebug
        |=> resumeTarget == $past(wdata))
        else $error("resume counter write not visible");

endmodule

// >>> tb/cache_array_model.sv
// behavioural tag, way-select, data and scratchpad arrays
`timescale 1ns/10ps
module cache_array_model (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // requests from the block
    input  wire logic        tagReq,
    input  wire logic        waySelReq,
    input  wire logic        dataReq,
    input  wire logic        scratchReq,
    input  wire logic        reqWrite,
    input  wire logic [31:0] reqWdata,
    input  wire logic        slow,
    // load-tag answers
    output logic             loadRetValid,
    output logic      [31:0] loadRetData
);
    logic [31:0] tagMem, wayMem, padMem, dataMem, pend;
    int          cnt;

    // one entry per array; answer after one or three cycles
    always @(posedge clk_sys) begin
        loadRetValid <= 1'b0;
        // stale bus shows the inverse so nothing passes by chance
        if (loadRetValid) loadRetData <= ~loadRetData;
        if (rst) begin
            cnt         <= 0;
            loadRetData <= 32'h0000_0000;
            // known contents so early loads return no unknowns
            tagMem      <= 32'h0000_0000;
            wayMem      <= 32'h0000_0000;
            padMem      <= 32'h0000_0000;
            dataMem     <= 32'h0000_0000;
            pend        <= 32'h0000_0000;
        end else begin
            if (tagReq && reqWrite) tagMem <= reqWdata;
            if (waySelReq && reqWrite) wayMem <= {26'h0, reqWdata[5:0]};
            if (scratchReq && reqWrite) padMem <= reqWdata;
            if (dataReq) dataMem <= reqWdata;
            if (!reqWrite && (tagReq || waySelReq || scratchReq)) begin
                pend <= scratchReq ? padMem : waySelReq ? wayMem : tagMem;
                cnt  <= slow ? 3 : 1;
            end else if (cnt > 1) cnt <= cnt - 1;
            else if (cnt == 1) begin
                cnt          <= 0;
                loadRetValid <= 1'b1;
                loadRetData  <= pend;
            end
        end
    end
endmodule

// >>> tb/debug_cause_and_cache_test_regs_test.sv
// self-checking bench for the debug cause and cache test registers
`timescale 1ns/10ps
`include "cp0_debug_defs.svh"
module debug_cause_and_cache_test_regs_test;
    import cp0_debug_pkg::*;
    localparam logic [31:0] TMASK = 32'hFFFF_FCF6;
    logic clk_sys = 0, rst = 1, wr = 0, rd = 0, rdPend = 0, slow = 0;
    logic debugExcTaken = 0, excInDebug = 0, excInDelaySlot = 0;
    logic debugReturn = 0, cacheOpValid = 0, lineFill = 0;
    logic singleStepEnable, delaySlotFlag, resumeJump, loadRetValid;
    logic tagReq, waySelReq, dataReq, scratchReq, reqWrite;
    logic [4:0]  excCauseCode = 0;
    logic [5:0]  debugKind = 0;
    logic [7:0]  addr = 0;
    logic [11:0] cacheIndex = 0, reqIndex;
    logic [31:0] wdata = 0, excPc = 0, excBranchPc = 0, lfsr = 49;
    logic [31:0] rdata, resumeTarget, reqWdata, loadRetData, t, v, w;
    logic [3:0]  em;
    cache_op_t   cacheOpKind = CACHE_LOAD_TAG;
    cache_op_t   ks[3] = '{CACHE_LOAD_TAG, CACHE_STORE_TAG, CACHE_STORE_DATA};
    logic [31:0] expQ[$], mskQ[$];
    int          err_total = 0, checked = 0, cycles = 0;

    debug_cause_and_cache_test_regs u_dut (.clk_sys, .rst, .addr, .wdata,
        .wr, .rd, .rdata, .debugExcTaken, .debugKind, .excInDebug,
        .excCauseCode, .excPc, .excInDelaySlot, .excBranchPc, .debugReturn,
        .singleStepEnable, .delaySlotFlag, .resumeJump, .resumeTarget,
        .cacheOpValid, .cacheOpKind, .cacheIndex, .loadRetValid, .loadRetData,
        .lineFill, .tagReq, .waySelReq, .dataReq, .scratchReq, .reqWrite,
        .reqWdata, .reqIndex);
    cache_array_model u_cache (.clk_sys, .rst, .tagReq, .waySelReq, .dataReq,
        .scratchReq, .reqWrite, .reqWdata, .slow, .loadRetValid, .loadRetData);

    initial forever #50 clk_sys = ~clk_sys;

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // bus cycles: one strobe cycle, then a free cycle before the next
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 0;
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, m);
        @(posedge clk_sys);
        rd <= 1;
        addr <= a;
        expQ.push_back(e & m);
        mskQ.push_back(m);
        @(posedge clk_sys);
        rd <= 0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk_sys) begin
        rdPend <= rd;
        if (rdPend) begin
            check("rdata", rdata & mskQ[0], expQ.pop_front());
            void'(mskQ.pop_front());
        end else if (!rst) begin
            check("rdataIdle", rdata, 0);
        end
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end

    task automatic dbg(input logic ent, input logic [5:0] k,
                       input logic [4:0] c, input logic ds);
        @(posedge clk_sys);
        debugExcTaken <= ent;
        excInDebug <= !ent;
        debugKind <= k;
        excCauseCode <= c;
        excInDelaySlot <= ds;
        excPc <= t;
        excBranchPc <= v;
        @(posedge clk_sys);
        debugExcTaken <= 0;
        excInDebug <= 0;
        #1;
    endtask

    task automatic cache_op(input cache_op_t k, input logic [3:0] m,
                            input logic [11:0] ix);
        @(posedge clk_sys);
        cacheOpValid <= 1;
        cacheOpKind <= k;
        cacheIndex <= ix;
        @(posedge clk_sys);
        cacheOpValid <= 0;
        #1;
        check("route", {tagReq, waySelReq, dataReq, scratchReq}, m);
        if (m != 0) begin
            check("reqWrite", reqWrite, k != CACHE_LOAD_TAG);
            check("reqIndex", reqIndex, ix);
        end
    endtask

    // load answers come back late; bounded wait
    task automatic wait_ret();
        int n;
        n = 0;
        while (loadRetValid !== 1'b1 && n < 10) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("loadRet", loadRetValid, 1);
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 0;
        rd_reg(`ADDR_DEBUG_STATUS, 0, 32'h0000_03C0);
        rd_reg(`ADDR_CACHE_TEST, 0, '1);
        rd_reg(8'h00, 0, '1);
        rd_reg(8'h7c, 0, '1);
        wr_reg(`ADDR_DEBUG_STATUS, '1);
        check("stepEn", singleStepEnable, 1);
        rd_reg(`ADDR_DEBUG_STATUS, 32'h0000_0120, 32'h0000_03FF);
        wr_reg(`ADDR_DEBUG_STATUS, 32'h0000_0100);
        // each entry cause in turn, odd ones from a delay slot
        for (int k = 0; k < 6; k++) begin
            t = rnd();
            v = rnd();
            dbg(1, 6'(1 << k), 0, k % 2);
            check("resume", resumeTarget, (k != 5 && k % 2) ? v : t);
            check("slot", delaySlotFlag, k != 5 && k % 2);
            rd_reg(`ADDR_DEBUG_STATUS, 32'h100 | (1 << k), 32'h3FF);
        end
        t = rnd();
        dbg(0, 0, t[4:0], 0);
        check("resume", resumeTarget, t);
        rd_reg(`ADDR_DEBUG_STATUS, {17'h0, t[4:0], 10'h100}, '1);
        t = rnd();
        wr_reg(`ADDR_RESUME_CNT, t);
        rd_reg(`ADDR_RESUME_CNT, t, '1);
        @(posedge clk_sys);
        debugReturn <= 1;
        @(posedge clk_sys);
        debugReturn <= 0;
        #1;
        check("jump", resumeJump, 1);
        check("target", resumeTarget, t);
        @(posedge clk_sys);
        #1;
        check("jump", resumeJump, 0);
        wr_reg(`ADDR_CACHE_TEST, '1);
        rd_reg(`ADDR_CACHE_TEST, 32'h3000_0000, '1);
        // every op kind under every control setting
        for (int c = 0; c < 4; c++) begin
            wr_reg(`ADDR_CACHE_TEST, 32'(c) << 28);
            for (int j = 0; j < 3; j++) begin
                em = c[0] ? 4'b0001 : c[1] ? (j == 2 ? 4'b0010 : 4'b0100)
                                           : (j == 2 ? 4'b0000 : 4'b1000);
                t = rnd();
                cache_op(ks[j], em, t[11:0]);
            end
        end
        wr_reg(`ADDR_CACHE_TEST, 0);
        t = rnd();
        wr_reg(`ADDR_TAG_STAGING, t);
        rd_reg(`ADDR_TAG_STAGING, t, TMASK);
        @(posedge clk_sys);
        lineFill <= 1;
        @(posedge clk_sys);
        lineFill <= 0;
        t = (t & TMASK) ^ 32'h0000_0002;
        rd_reg(`ADDR_TAG_STAGING, t, '1);
        cache_op(CACHE_STORE_TAG, 4'b1000, 0);
        check("tagWdata", reqWdata, t);
        wr_reg(`ADDR_TAG_STAGING, rnd());
        slow <= 1;
        cache_op(CACHE_LOAD_TAG, 4'b1000, 0);
        wait_ret();
        rd_reg(`ADDR_TAG_STAGING, t, '1);
        // way-select test: only the low address bits travel
        wr_reg(`ADDR_CACHE_TEST, 32'h2000_0000);
        v = rnd();
        wr_reg(`ADDR_TAG_STAGING, v);
        cache_op(CACHE_STORE_TAG, 4'b0100, 1);
        check("wayWdata", reqWdata, {26'h0, v[15:10]});
        w = rnd();
        wr_reg(`ADDR_TAG_STAGING, w);
        cache_op(CACHE_LOAD_TAG, 4'b0100, 1);
        wait_ret();
        rd_reg(`ADDR_TAG_STAGING, {w[31:16], v[15:10], w[9:0]}, TMASK);
        wr_reg(`ADDR_DATA_STAGING, w);
        cache_op(CACHE_STORE_DATA, 4'b0010, 2);
        check("dataWdata", reqWdata, w);
        wr_reg(`ADDR_CACHE_TEST, 0);
        slow <= 0;
        cache_op(CACHE_LOAD_TAG, 4'b1000, 3);
        wait_ret();
        rd_reg(`ADDR_TAG_STAGING, t, '1);
        // let the last read data reach the monitor before the verdict
        repeat (2) @(posedge clk_sys);
        check("pending", expQ.size(), 0);
        finish_test();
    end
endmodule
